/* rtl/fls_pkg.sv */
`default_nettype none

package fls_pkg;

    // ==========================================================
    // Timing.
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
    localparam int TICK_W         = 18;

    // ==========================================================
    // Register byte offsets.
    localparam logic [5:0] OFS_CTRL       = 6'h00;
    localparam logic [5:0] OFS_STATUS     = 6'h04;
    localparam logic [5:0] OFS_WARM_THR   = 6'h08;
    localparam logic [5:0] OFS_SB_NORMAL  = 6'h0C;
    localparam logic [5:0] OFS_SB_LOW     = 6'h10;
    localparam logic [5:0] OFS_SB_HIGH    = 6'h14;
    localparam logic [5:0] OFS_LL_NORMAL  = 6'h18;
    localparam logic [5:0] OFS_LL_LOW     = 6'h1C;
    localparam logic [5:0] OFS_LL_HIGH    = 6'h20;
    localparam logic [5:0] OFS_SMALL_CORR = 6'h24;
    localparam logic [5:0] OFS_NORM_CORR  = 6'h28;
    localparam logic [5:0] OFS_TRACE_CORR = 6'h2C;
    localparam logic [5:0] OFS_LOWPWR_SP  = 6'h30;
    localparam logic [5:0] OFS_IDLE_START = 6'h34;

    // ==========================================================
    // Control and status field positions.
    localparam int CTRL_JOB   = 0;
    localparam int CTRL_LOWP  = 1;
    localparam int CTRL_TMODE = 2;
    localparam int CTRL_TRACE = 4;
    localparam int CTRL_B257  = 5;
    localparam int CTRL_SMALL = 6;
    localparam int CTRL_WIDTH = 16;
    localparam int STAT_HALT_SEEN = 7;

    // ==========================================================
    // Reset values, the eight arrays indexed by variant 0, 1, 2, and the hysteresis.
    localparam logic [2:0][7:0] SB_N_DEF  = {8'hB2, 8'hA5, 8'h99};
    localparam logic [2:0][7:0] SB_L_DEF  = {8'hBC, 8'hAF, 8'hA3};
    localparam logic [2:0][7:0] SB_H_DEF  = {8'hAD, 8'hA0, 8'h94};
    localparam logic [2:0][7:0] LL_N_DEF  = {8'h9E, 8'h91, 8'h85};
    localparam logic [2:0][7:0] LL_L_DEF  = {8'hA8, 8'h9B, 8'h8F};
    localparam logic [2:0][7:0] LL_H_DEF  = {8'h99, 8'h8C, 8'h7B};
    localparam logic [2:0][7:0] WARM_DEF  = {8'h5F, 8'h63, 8'h63};
    localparam logic [2:0][7:0] IDLE_DEF  = {8'hA0, 8'h82, 8'h82};
    localparam logic [7:0] SMALL_DEF  = 8'h0A;
    localparam logic [7:0] NORM_DEF   = 8'h05;
    localparam logic [7:0] TRACE_DEF  = 8'h00;
    localparam logic [7:0] HYST       = 8'h02;

    // ==========================================================
    // Programmable ranges and paper widths.
    localparam logic [7:0] WARM_MIN  = 8'h14;
    localparam logic [7:0] WARM_MAX  = 8'hBE;
    localparam logic [7:0] SB_MIN    = 8'h8C;
    localparam logic [7:0] SB_MAX    = 8'hBE;
    localparam logic [7:0] LL_MIN    = 8'h78;
    localparam logic [7:0] LL_MAX    = 8'hB4;
    localparam logic [7:0] SMALL_MAX = 8'h14;
    localparam logic [7:0] NORM_MAX  = 8'h0A;
    localparam logic [7:0] TRACE_LIM = 8'h0A;
    localparam logic [7:0] IDLE_MIN  = 8'h64;
    localparam logic [7:0] IDLE_MAX  = 8'hA0;
    localparam logic [9:0] WIDTH_297 = 10'h129;
    localparam logic [9:0] WIDTH_257 = 10'h101;

    // ==========================================================
    // Lamp orders: two-bit lamp indices, first lamp in the low bits.
    localparam logic [5:0] ORD_321 = {2'h0, 2'h1, 2'h2};
    localparam logic [5:0] ORD_132 = {2'h1, 2'h2, 2'h0};
    localparam logic [5:0] ORD_231 = {2'h0, 2'h2, 2'h1};
    localparam logic [5:0] ORD_123 = {2'h2, 2'h1, 2'h0};
    localparam logic [5:0] ORD_213 = {2'h2, 2'h0, 2'h1};

    typedef enum logic [2:0] {
        ST_WARM_START,
        ST_WARMUP,
        ST_STANDBY,
        ST_JOB,
        ST_LOWPWR
    } fls_state_t;

endpackage : fls_pkg

`default_nettype wire

/* rtl/fls_fuser_ctrl.sv */
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module fls_fuser_ctrl
    import fls_pkg::*;
#(
    parameter int VARIANT     = 0,
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter logic [7:0] LOWPWR_SP_DEF = 8'h8C
)(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  therm_temp,
    output logic      [2:0]  lamp_on,
    output logic             job_halt
);

    localparam bit FAST = (VARIANT == 2);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [7:0]        sync1;
        logic [7:0]        sync2;
        logic [7:0]        temp;
        logic [TICK_W-1:0] tick_cnt;
        fls_state_t        state;
        logic [2:0]        lamps;
        logic [2:0]        keep;
        logic              heat;
        logic              alt;
        logic              wu_lamp1;
        logic              reached;
        logic              halt;
        logic              halt_seen;
        logic [31:0]       ctrl;
        logic [7:0]        warm_thr;
        logic [7:0]        sb_n;
        logic [7:0]        sb_l;
        logic [7:0]        sb_h;
        logic [7:0]        ll_n;
        logic [7:0]        ll_l;
        logic [7:0]        ll_h;
        logic [7:0]        small_c;
        logic [7:0]        norm_c;
        logic [7:0]        trace_c;
        logic [7:0]        lp_sp;
        logic [7:0]        idle_t;
        logic              wait_r;
        logic [31:0]       rdata;
    } fls_st_t;

    localparam fls_st_t RST = '{
        sync1: 8'h00, sync2: 8'h00, temp: 8'h00, tick_cnt: '0,
        state: ST_WARM_START, lamps: 3'h0, keep: 3'h0,
        heat: 1'b0, alt: 1'b0, wu_lamp1: 1'b0, reached: 1'b0,
        halt: 1'b0, halt_seen: 1'b0, ctrl: 32'h0000_0000,
        warm_thr: WARM_DEF[VARIANT], sb_n: SB_N_DEF[VARIANT],
        sb_l: SB_L_DEF[VARIANT], sb_h: SB_H_DEF[VARIANT],
        ll_n: LL_N_DEF[VARIANT], ll_l: LL_L_DEF[VARIANT],
        ll_h: LL_H_DEF[VARIANT], small_c: SMALL_DEF, norm_c: NORM_DEF,
        trace_c: TRACE_DEF, lp_sp: LOWPWR_SP_DEF, idle_t: IDLE_DEF[VARIANT],
        wait_r: 1'b1, rdata: 32'h0000_0000
    };

    fls_st_t s;
    fls_st_t n;

    // ==========================================================
    // Helpers.
    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        if (v < lo)
        begin
            return lo;
        end
        if (v > hi)
        begin
            return hi;
        end
        return v;
    endfunction : clamp8

    function automatic logic [2:0] lamp_step(input logic [2:0] lit,
                                             input logic [2:0] tgt,
                                             input logic [5:0] on_o,
                                             input logic [5:0] off_o);
        logic [2:0] r;
        logic       done;
        r    = lit;
        done = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (!done && lit[off_o[2*i +: 2]] && !tgt[off_o[2*i +: 2]])
            begin
                r[off_o[2*i +: 2]] = 1'b0;
                done               = 1'b1;
            end
        end
        for (int i = 0; i < 3; i++)
        begin
            if (!done && !lit[on_o[2*i +: 2]] && tgt[on_o[2*i +: 2]])
            begin
                r[on_o[2*i +: 2]] = 1'b1;
                done              = 1'b1;
            end
        end
        return r;
    endfunction : lamp_step

    // ==========================================================
    // Decoded settings and thresholds.
    logic               tick;
    logic               wr_en;
    logic               rd_cap;
    logic [7:0]         sb_sel;
    logic [7:0]         ll_sel;
    logic               normal_paper;
    logic signed [10:0] corr;
    logic signed [10:0] on_thr;
    logic signed [10:0] smp;
    logic [2:0]         base;
    logic [2:0]         single;
    logic [2:0]         tgt;
    logic [5:0]         on_o;
    logic [5:0]         off_o;

    always_comb
    begin
        tick   = (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
        wr_en  = avs_write && !s.wait_r;
        rd_cap = avs_read && s.wait_r;
        smp    = $signed({3'h0, s.sync2});
        unique case (s.ctrl[CTRL_TMODE +: 2])
            2'h1:    begin sb_sel = s.sb_l; ll_sel = s.ll_l; end
            2'h2:    begin sb_sel = s.sb_h; ll_sel = s.ll_h; end
            default: begin sb_sel = s.sb_n; ll_sel = s.ll_n; end
        endcase
        normal_paper = s.ctrl[CTRL_WIDTH +: 10] >=
                       (s.ctrl[CTRL_B257] ? WIDTH_257 : WIDTH_297);
        if (s.ctrl[CTRL_TRACE])
        begin
            corr = 11'(signed'(s.trace_c));
        end
        else if (normal_paper)
        begin
            corr = $signed({3'h0, s.norm_c});
        end
        else
        begin
            corr = $signed({3'h0, s.small_c});
        end
        unique case (s.state)
            ST_JOB:    on_thr = $signed({3'h0, sb_sel}) + corr;
            ST_LOWPWR: on_thr = $signed({3'h0, s.lp_sp});
            default:   on_thr = $signed({3'h0, sb_sel});
        endcase
        single = (FAST && s.alt) || (!FAST && s.state == ST_LOWPWR) ?
                 3'h4 : 3'h2;
        if (s.ctrl[CTRL_TRACE] || normal_paper)
        begin
            base  = FAST ? 3'h7 : 3'h5;
            on_o  = ORD_132;
            off_o = ORD_231;
        end
        else
        begin
            unique case (s.ctrl[CTRL_SMALL +: 2])
                2'h0:    begin base = 3'h3; on_o = ORD_123; off_o = ORD_321; end
                2'h1:    begin base = 3'h5; on_o = ORD_132; off_o = ORD_231; end
                default: begin base = 3'h1; on_o = ORD_123; off_o = ORD_231; end
            endcase
        end
        tgt = 3'h0;
        unique case (s.state)
            ST_WARM_START:
            begin
                on_o  = ORD_321;
                off_o = ORD_132;
            end
            ST_WARMUP:
            begin
                tgt   = {!s.reached, !s.reached, s.wu_lamp1};
                on_o  = ORD_321;
                off_o = ORD_132;
            end
            ST_STANDBY, ST_LOWPWR:
            begin
                tgt   = s.heat ? single : 3'h0;
                on_o  = ORD_213;
                off_o = ORD_123;
            end
            ST_JOB:
            begin
                tgt = s.heat ? (base | s.keep) : 3'h0;
            end
        endcase
    end

    // ==========================================================
    // Next state.
    always_comb
    begin
        n          = s;
        n.sync1    = therm_temp;
        n.sync2    = s.sync1;
        n.tick_cnt = tick ? '0 : s.tick_cnt + TICK_W'(1);
        n.wait_r   = !((avs_read || avs_write) && s.wait_r);

        if (rd_cap)
        begin
            unique case (avs_address)
                OFS_CTRL:       n.rdata = s.ctrl;
                OFS_STATUS:     n.rdata = {15'h0000, s.heat, s.temp, s.halt_seen,
                                           s.state, s.halt, s.lamps};
                OFS_WARM_THR:   n.rdata = {24'h000000, s.warm_thr};
                OFS_SB_NORMAL:  n.rdata = {24'h000000, s.sb_n};
                OFS_SB_LOW:     n.rdata = {24'h000000, s.sb_l};
                OFS_SB_HIGH:    n.rdata = {24'h000000, s.sb_h};
                OFS_LL_NORMAL:  n.rdata = {24'h000000, s.ll_n};
                OFS_LL_LOW:     n.rdata = {24'h000000, s.ll_l};
                OFS_LL_HIGH:    n.rdata = {24'h000000, s.ll_h};
                OFS_SMALL_CORR: n.rdata = {24'h000000, s.small_c};
                OFS_NORM_CORR:  n.rdata = {24'h000000, s.norm_c};
                OFS_TRACE_CORR: n.rdata = {24'h000000, s.trace_c};
                OFS_LOWPWR_SP:  n.rdata = {24'h000000, s.lp_sp};
                OFS_IDLE_START: n.rdata = {24'h000000, s.idle_t};
                default:        n.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_en)
        begin
            if (avs_address == OFS_CTRL)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (avs_byteenable[b])
                    begin
                        n.ctrl[8*b +: 8] = avs_writedata[8*b +: 8];
                    end
                end
                n.ctrl[15:8]  = 8'h00;
                n.ctrl[31:26] = 6'h00;
            end
            if (avs_byteenable[0])
            begin
                unique case (avs_address)
                    OFS_STATUS:
                    begin
                        if (avs_writedata[STAT_HALT_SEEN])
                        begin
                            n.halt_seen = 1'b0;
                        end
                    end
                    OFS_WARM_THR:   n.warm_thr = clamp8(avs_writedata[7:0],
                                                        WARM_MIN, WARM_MAX);
                    OFS_SB_NORMAL:  n.sb_n = clamp8(avs_writedata[7:0],
                                                    SB_MIN, SB_MAX);
                    OFS_SB_LOW:     n.sb_l = clamp8(avs_writedata[7:0], SB_MIN, SB_MAX);
                    OFS_SB_HIGH:    n.sb_h = clamp8(avs_writedata[7:0], SB_MIN, SB_MAX);
                    OFS_LL_NORMAL:  n.ll_n = clamp8(avs_writedata[7:0], LL_MIN, LL_MAX);
                    OFS_LL_LOW:     n.ll_l = clamp8(avs_writedata[7:0], LL_MIN, LL_MAX);
                    OFS_LL_HIGH:    n.ll_h = clamp8(avs_writedata[7:0], LL_MIN, LL_MAX);
                    OFS_SMALL_CORR: n.small_c = clamp8(avs_writedata[7:0],
                                                       8'h00, SMALL_MAX);
                    OFS_NORM_CORR:  n.norm_c = clamp8(avs_writedata[7:0], 8'h00, NORM_MAX);
                    OFS_TRACE_CORR:
                    begin
                        if ($signed(avs_writedata[7:0]) > $signed(TRACE_LIM))
                        begin
                            n.trace_c = TRACE_LIM;
                        end
                        else if ($signed(avs_writedata[7:0]) < -$signed(TRACE_LIM))
                        begin
                            n.trace_c = -TRACE_LIM;
                        end
                        else
                        begin
                            n.trace_c = avs_writedata[7:0];
                        end
                    end
                    OFS_LOWPWR_SP:  n.lp_sp = avs_writedata[7:0];
                    OFS_IDLE_START: n.idle_t = clamp8(avs_writedata[7:0],
                                                      IDLE_MIN, IDLE_MAX);
                    default:        n.lp_sp = s.lp_sp;
                endcase
            end
        end

        if (tick)
        begin
            n.temp  = s.sync2;
            n.lamps = lamp_step(s.lamps, tgt, on_o, off_o);
            if (smp < on_thr)
            begin
                n.heat = 1'b1;
            end
            else if (smp > on_thr + $signed({3'h0, HYST}))
            begin
                n.heat = 1'b0;
            end
            if (FAST && !s.heat && n.heat)
            begin
                n.alt = !s.alt;
            end
            unique case (s.state)
                ST_WARM_START:
                begin
                    n.wu_lamp1 = smp < $signed({3'h0, s.warm_thr});
                    n.reached  = 1'b0;
                    n.state    = ST_WARMUP;
                end
                ST_WARMUP:
                begin
                    if (smp >= $signed({3'h0, s.warm_thr}))
                    begin
                        n.wu_lamp1 = 1'b0;
                    end
                    if (smp >= $signed({3'h0, sb_sel}))
                    begin
                        n.reached = 1'b1;
                    end
                    if (s.reached && s.lamps == 3'h0)
                    begin
                        n.heat  = 1'b0;
                        n.state = ST_STANDBY;
                    end
                end
                ST_STANDBY:
                begin
                    if (s.ctrl[CTRL_LOWP])
                    begin
                        n.state = ST_LOWPWR;
                    end
                    else if (s.ctrl[CTRL_JOB])
                    begin
                        n.keep  = FAST ? (s.lamps & 3'h6) : 3'h0;
                        n.state = ST_JOB;
                    end
                end
                ST_JOB:
                begin
                    if ((s.lamps & base) == base)
                    begin
                        n.keep = 3'h0;
                    end
                    if (smp < $signed({3'h0, ll_sel}))
                    begin
                        n.halt      = 1'b1;
                        n.halt_seen = 1'b1;
                    end
                    else if (s.halt && smp >= on_thr)
                    begin
                        n.halt = 1'b0;
                    end
                    if (!s.ctrl[CTRL_JOB])
                    begin
                        n.keep  = 3'h0;
                        n.halt  = 1'b0;
                        n.state = ST_STANDBY;
                    end
                end
                ST_LOWPWR:
                begin
                    if (!s.ctrl[CTRL_LOWP])
                    begin
                        n.state = ST_STANDBY;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Registers and outputs.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign lamp_on         = s.lamps;
    assign job_halt        = s.halt;
    assign avs_waitrequest = s.wait_r;
    assign avs_readdata    = s.rdata;

endmodule : fls_fuser_ctrl

`default_nettype wire

/* tb/fls_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus handshake and lamp switching checks.
module fls_ctrl_sva
    import fls_pkg::*;
#(
    parameter int TICK_CYCLES = 8
)(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  lamp_on,
    input wire logic        job_halt
);
    logic [2:0] prev_reg;
    logic [7:0] gap_reg;
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            prev_reg <= 3'h0;
        else
            prev_reg <= lamp_on;
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            gap_reg <= 8'hFF;
        else if (lamp_on != prev_reg)
            gap_reg <= 8'h00;
        else if (gap_reg != 8'hFF)
            gap_reg <= gap_reg + 8'h01;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered after one wait cycle");
    a_wait_low_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_no_req: assert property (!(avs_read || avs_write) && avs_waitrequest
        |=> avs_waitrequest) else $error("answer without a request");
    a_rdata_stands: assert property ($changed(avs_readdata)
        |-> !avs_waitrequest && $past(avs_read)) else $error("read data moved without a read");
    a_narrow_upper: assert property (avs_read && !avs_waitrequest
        && avs_address != OFS_CTRL && avs_address != OFS_STATUS |-> avs_readdata[31:8] == 24'h0)
        else $error("narrow register upper bits not zero");
    a_reset_quiet: assert property ($past(!rstn) |-> lamp_on == 3'h0 && !job_halt
        && avs_waitrequest) else $error("outputs not idle after reset");
    a_one_lamp_step: assert property ($countones(lamp_on ^ prev_reg) <= 1)
        else $error("more than one lamp changed at once");
    a_lamp_tick_gap: assert property (lamp_on != prev_reg
        |-> int'(gap_reg) >= TICK_CYCLES - 2) else $error("lamp changes closer than one tick");
    c_read_done: cover property (avs_read && !avs_waitrequest);
    c_all_lamps: cover property (lamp_on == 3'h7);
    c_halt_rise: cover property ($rose(job_halt));
endmodule : fls_ctrl_sva
bind fls_fuser_ctrl fls_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) fls_ctrl_sva_inst (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lamp_on(lamp_on), .job_halt(job_halt));
`default_nettype wire

/* tb/fls_roller_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Hot roller: lit lamps heat it unless cool_fast forces cooling, otherwise it cools down to 8'h14.
module fls_roller_model #(
    parameter int STEP = 8
)(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [2:0] lamp_on,
    input  wire logic       cool_fast,
    output logic      [7:0] therm_temp
);
    int cnt;
    always @(posedge core_clk or negedge rstn)
        if (!rstn)
        begin
            cnt <= 0;
            therm_temp <= 8'h1E;
        end
        else if (cnt == STEP - 1)
        begin
            cnt <= 0;
            if (cool_fast)
                therm_temp <= therm_temp - 8'h03;
            else if (lamp_on != 3'h0)
                therm_temp <= therm_temp + 8'($countones(lamp_on));
            else if (therm_temp > 8'h14)
                therm_temp <= therm_temp - 8'h01;
        end
        else
            cnt <= cnt + 1;
endmodule : fls_roller_model
`default_nettype wire

/* tb/fls_fuser_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
// ==========================================================
// Register, warm-up, job and low power sequences.
module fls_fuser_ctrl_tb_top
    import fls_pkg::*;
;
    logic        clk, rstn, rd, wr, cool, halt, waitreq;
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  temp;
    logic [2:0]  lamps;
    int          error_cnt, n_checks;
    logic [5:0]  ofs_tab [13] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20,
                                  6'h24, 6'h28, 6'h2C, 6'h30, 6'h34, 6'h38};
    logic [7:0]  dflt_tab [13] = '{8'h63, 8'h99, 8'hA3, 8'h94, 8'h85, 8'h8F, 8'h7B,
                                   8'h0A, 8'h05, 8'h00, 8'h8C, 8'h82, 8'h00};
    fls_fuser_ctrl #(.VARIANT(0), .TICK_CYCLES(8)) fls_fuser_ctrl_inst (
        .core_clk(clk), .rstn(rstn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .therm_temp(temp), .lamp_on(lamps), .job_halt(halt));
    fls_roller_model #(.STEP(8)) fls_roller_model_inst (
        .core_clk(clk), .rstn(rstn), .lamp_on(lamps), .cool_fast(cool), .therm_temp(temp));
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rchk
    task automatic nxt(input logic [2:0] e, input logic chg);
        logic [2:0] p;
        p = lamps;
        repeat (8000) if (chg ? lamps === p : lamps !== e) @(posedge clk);
        `CHK(lamps, e)
    endtask : nxt
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        {rstn, rd, wr, cool, addr, wdata} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        nxt(3'b100, 1);
        nxt(3'b110, 1);
        nxt(3'b111, 1);
        nxt(3'b110, 1);
        `CHK(temp >= 8'h63, 1'b1)
        nxt(3'b010, 1);
        `CHK(temp >= 8'h99, 1'b1)
        nxt(3'b000, 1);
        nxt(3'b010, 1);
        `CHK(temp < 8'h99, 1'b1)
        nxt(3'b000, 1);
        `CHK(temp > 8'h9B, 1'b1)
        bus(1'b1, OFS_CTRL, 32'h0129_0001);
        nxt(3'b001, 1);
        nxt(3'b101, 1);
        nxt(3'b001, 1);
        `CHK(temp > 8'hA0, 1'b1)
        nxt(3'b000, 1);
        foreach (ofs_tab[i]) rchk(ofs_tab[i], {24'h0, dflt_tab[i]});
        bus(1'b1, OFS_WARM_THR, 32'h05);
        rchk(OFS_WARM_THR, 32'h14);
        bus(1'b1, OFS_SMALL_CORR, 32'hFF);
        rchk(OFS_SMALL_CORR, 32'h14);
        bus(1'b1, OFS_SMALL_CORR, 32'h0A);
        cool <= 1'b1;
        nxt(3'b101, 0);
        repeat (8000) if (halt !== 1'b1) @(posedge clk);
        `CHK(halt, 1'b1)
        `CHK(temp < 8'h85, 1'b1)
        cool <= 1'b0;
        repeat (8000) if (halt !== 1'b0) @(posedge clk);
        `CHK(halt, 1'b0)
        `CHK(temp >= 8'h9E, 1'b1)
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[7], 1'b1)
        `CHK(q[3], 1'b0)
        bus(1'b1, OFS_STATUS, 32'h80);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[7], 1'b0)
        bus(1'b1, OFS_CTRL, 32'h0);
        nxt(3'b000, 0);
        bus(1'b1, OFS_CTRL, 32'h0128_0001);
        nxt(3'b001, 1);
        nxt(3'b011, 1);
        nxt(3'b001, 1);
        `CHK(temp > 8'hA5, 1'b1)
        bus(1'b1, OFS_CTRL, 32'h2);
        nxt(3'b100, 0);
        `CHK(temp < 8'h8C, 1'b1)
        bus(1'b1, OFS_CTRL, 32'h0100_0011);
        nxt(3'b101, 0);
        nxt(3'b001, 1);
        `CHK(temp > 8'h9B, 1'b1)
        finish_test();
    end
endmodule : fls_fuser_ctrl_tb_top
`undef CHK
`default_nettype wire
